// >>> pkg/arc_pkg.sv
// How it works
// - each analog channel pin can be converted or read as a port pin.
// - four dedicated trigger inputs can each start a conversion sequence.
// - one digital buffer enable bit per channel, 0 disconnects and 1 connects the pin.
// - a set buffer enable stays in force even while the pin is being sampled.
// - any write to the compare direction register aborts the running sequence.
// - with direction bit 0 the compare flag sets when the result is lower or equal.
// - with direction bit 1 the compare flag sets when the result is strictly higher.
// - 8-bit left justified results sit in bits 11..4 with bits 3..0 zero.
// - 8-bit right justified results sit in bits 7..0 with bits 11..8 zero.
// - 10-bit left justified results sit in bits 11..2 with bits 1..0 zero.
// - 10-bit right justified results sit in bits 9..0 with bits 11..10 zero.
package arc_pkg;
  // ==========================================
  // register offsets
  localparam logic [4:0] ARC_OFS_CMP_DIR = 5'h0E;
  localparam logic [4:0] ARC_OFS_DIG_EN = 5'h10;
  localparam logic [4:0] ARC_OFS_CTRL = 5'h12;
  localparam logic [4:0] ARC_OFS_TRIG_SEL = 5'h14;
  localparam logic [4:0] ARC_OFS_STATUS = 5'h16;
  localparam logic [4:0] ARC_OFS_MASK = 5'h18;
  localparam logic [4:0] ARC_OFS_CMP_FLAG = 5'h1A;
  localparam logic [4:0] ARC_OFS_PORT_DATA = 5'h1C;
  localparam logic [4:0] ARC_OFS_RESULT = 5'h00;
  // ==========================================
  // control and status fields
  localparam int ARC_CTRL_RES_LSB = 0;
  localparam int ARC_CTRL_JUSTIFY = 2;
  localparam int ARC_CTRL_START = 3;
  localparam int ARC_CTRL_TRIG_EN = 4;
  localparam int ARC_STAT_DONE = 0;
  localparam int ARC_STAT_CMP = 1;
  localparam int ARC_STAT_ABORT = 2;
  // ==========================================
  // reset values
  localparam logic [15:0] ARC_RST_CMP_DIR = 16'h0000;
  localparam logic [15:0] ARC_RST_DIG_EN = 16'h0000;
  localparam logic [4:0] ARC_RST_CTRL = 5'h00;
  localparam logic [2:0] ARC_RST_STATUS = 3'h0;
  // ==========================================
  // resolutions
  localparam logic [1:0] ARC_RES_8 = 2'h0;
  localparam logic [1:0] ARC_RES_10 = 2'h1;
  localparam logic [1:0] ARC_RES_12 = 2'h2;
endpackage : arc_pkg

// >>> rtl/arc_result_format.sv
`timescale 1ns/100ps
module arc_result_format
  import arc_pkg::*;
(
  input wire logic [1:0] resolution,
  input wire logic justify_right,
  input wire logic [11:0] raw_result,
  output logic [11:0] placed_result
);
  // raw result is right aligned at its own resolution
  always_comb begin
    case (resolution)
      ARC_RES_8: begin
        if (justify_right) begin
          placed_result = {4'h0, raw_result[7:0]};
        end else begin
          placed_result = {raw_result[7:0], 4'h0};
        end
      end
      ARC_RES_10: begin
        if (justify_right) begin
          placed_result = {2'h0, raw_result[9:0]};
        end else begin
          placed_result = {raw_result[9:0], 2'h0};
        end
      end
      default: placed_result = raw_result;
    endcase
  end
endmodule : arc_result_format

// >>> rtl/arc_converter_ctrl.sv
`timescale 1ns/100ps
module arc_converter_ctrl
  import arc_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [CHANNELS-1:0] analog_input_channel,
  input wire logic [3:0] external_trigger_input,
  output logic [CHANNELS-1:0] digital_buffer_enable_bits,
  output logic sequence_start,
  output logic sequence_abort,
  input wire logic conv_valid,
  input wire logic [3:0] conv_index,
  input wire logic [11:0] conv_raw,
  output logic irq
);
  // ==========================================
  // pin synchronisers
  logic [CHANNELS-1:0] pin_meta;
  logic [CHANNELS-1:0] pin_sync;
  logic [3:0] trig_meta;
  logic [3:0] trig_sync;
  logic [3:0] trig_prev;
  logic [15:0] compare_direction_select;
  logic [15:0] digital_input_enable;
  logic [4:0] ctrl;
  logic [3:0] trig_sel;
  logic [2:0] status;
  logic [2:0] mask;
  logic [15:0] compare_flag_status;
  logic [11:0] result_mem [CHANNELS];
  logic [11:0] placed;
  logic wr_cmp;
  logic cmp_hit;
  logic [2:0] next_status;
  logic [2:0] stat_set;
  logic trig_fire;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      trig_meta <= 4'h0;
      trig_sync <= 4'h0;
      trig_prev <= 4'h0;
    end else if (clk_en) begin
      pin_meta <= analog_input_channel;
      pin_sync <= pin_meta;
      trig_meta <= external_trigger_input;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  // buffer gate is static: analog sampling never touches it
  assign digital_buffer_enable_bits = digital_input_enable;

  // ==========================================
  // register writes
  assign wr_cmp = reg_wr && (reg_addr == ARC_OFS_CMP_DIR);

  // only even offsets below the direction register reach a result word
  function automatic logic is_result_addr(input logic [4:0] a);
    return (a < ARC_OFS_CMP_DIR) && !a[0];
  endfunction : is_result_addr

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_direction_select <= ARC_RST_CMP_DIR;
      digital_input_enable <= ARC_RST_DIG_EN;
      ctrl <= ARC_RST_CTRL;
      trig_sel <= 4'h0;
      mask <= 3'h0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        ARC_OFS_CMP_DIR: compare_direction_select <= reg_wdata;
        ARC_OFS_DIG_EN: digital_input_enable <= reg_wdata;
        ARC_OFS_CTRL: ctrl <= reg_wdata[4:0];
        ARC_OFS_TRIG_SEL: trig_sel <= reg_wdata[3:0];
        ARC_OFS_MASK: mask <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // sequence start and abort
  assign trig_fire = ctrl[ARC_CTRL_TRIG_EN] && |(trig_sel & trig_sync & ~trig_prev);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sequence_start <= 1'b0;
      sequence_abort <= 1'b0;
    end else if (clk_en) begin
      sequence_start <= (reg_wr && reg_addr == ARC_OFS_CTRL && reg_wdata[ARC_CTRL_START])
        || trig_fire;
      sequence_abort <= wr_cmp;
    end else begin
      sequence_start <= 1'b0;
      sequence_abort <= 1'b0;
    end
  end

  // ==========================================
  // result placement and compare
  arc_result_format u_fmt (
    .resolution(ctrl[ARC_CTRL_RES_LSB +: 2]),
    .justify_right(ctrl[ARC_CTRL_JUSTIFY]),
    .raw_result(conv_raw),
    .placed_result(placed)
  );

  // result register doubles as compare value
  always_comb begin
    if (compare_direction_select[conv_index]) begin
      cmp_hit = placed > result_mem[conv_index];
    end else begin
      cmp_hit = placed <= result_mem[conv_index];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        result_mem[i] <= 12'h000;
      end
    end else if (clk_en) begin
      if (reg_wr && is_result_addr(reg_addr)) begin
        result_mem[reg_addr[4:1]] <= reg_wdata[11:0];
      end
      // conversion wins over software write in same cycle
      if (conv_valid) begin
        result_mem[conv_index] <= placed;
      end
    end
  end

  // flag set wins over write-one clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_flag_status <= 16'h0000;
    end else if (clk_en) begin
      compare_flag_status <= (compare_flag_status &
        ~((reg_wr && reg_addr == ARC_OFS_CMP_FLAG) ? reg_wdata : 16'h0000)) |
        ((conv_valid && cmp_hit) ? (16'h0001 << conv_index) : 16'h0000);
    end
  end

  // ==========================================
  // interrupt status
  always_comb begin
    stat_set = 3'h0;
    stat_set[ARC_STAT_DONE] = conv_valid;
    stat_set[ARC_STAT_CMP] = conv_valid && cmp_hit;
    stat_set[ARC_STAT_ABORT] = wr_cmp;
    next_status = status;
    if (reg_wr && reg_addr == ARC_OFS_STATUS) begin
      next_status = status & ~reg_wdata[2:0];
    end
    next_status = next_status | stat_set;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status <= ARC_RST_STATUS;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  assign irq = |(status & mask);

  // ==========================================
  // read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        ARC_OFS_CMP_DIR: reg_rdata <= compare_direction_select;
        ARC_OFS_DIG_EN: reg_rdata <= digital_input_enable;
        ARC_OFS_CTRL: reg_rdata <= {11'h000, ctrl};
        ARC_OFS_TRIG_SEL: reg_rdata <= {12'h000, trig_sel};
        ARC_OFS_STATUS: reg_rdata <= {13'h0000, status};
        ARC_OFS_MASK: reg_rdata <= {13'h0000, mask};
        ARC_OFS_CMP_FLAG: reg_rdata <= compare_flag_status;
        // pins with buffer off read zero
        ARC_OFS_PORT_DATA: reg_rdata <= pin_sync & digital_input_enable;
        default: begin
          if (is_result_addr(reg_addr)) begin
            reg_rdata <= {4'h0, result_mem[reg_addr[4:1]]};
          end else begin
            reg_rdata <= 16'h0000;
          end
        end
      endcase
    end
  end
endmodule : arc_converter_ctrl

// >>> dv/arc_properties.sv
`timescale 1ns/100ps
module arc_properties
  import arc_pkg::*;
#(parameter int CHANNELS = 16) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [CHANNELS-1:0] digital_buffer_enable_bits,
  input wire logic sequence_start,
  input wire logic sequence_abort
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire wd = reg_wr && clk_en && reg_addr == ARC_OFS_CMP_DIR;
  wire we = reg_wr && clk_en && reg_addr == ARC_OFS_DIG_EN;
  abort_on_write_a:
    assert property (wd ##1 clk_en |-> sequence_abort) else $error("no abort");
  abort_cause_a:
    assert property (sequence_abort |-> $past(wd)) else $error("stray abort");
  frozen_quiet_a:
    assert property (!clk_en |=> !sequence_abort && !sequence_start) else $error("pulse frozen");
  enable_write_a:
    assert property (we |=> digital_buffer_enable_bits == $past(reg_wdata)) else $error("enable");
  enable_hold_a:
    assert property (!we |=> $stable(digital_buffer_enable_bits)) else $error("enable moved");
  enable_read_a:
    assert property ((reg_rd && clk_en && reg_addr == ARC_OFS_DIG_EN) |=>
      reg_rdata == digital_buffer_enable_bits) else $error("enable read");
  dir_readback_a:
    assert property (wd ##1 (reg_rd && clk_en && reg_addr == ARC_OFS_CMP_DIR) |=>
      reg_rdata == $past(reg_wdata, 2)) else $error("direction read");
  rdata_hold_a:
    assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata)) else $error("rdata moved");
  enable_reset_a:
    assert property ($fell(sys_rst) |-> digital_buffer_enable_bits == '0) else $error("reset");
endmodule : arc_properties
bind arc_converter_ctrl arc_properties #(.CHANNELS(CHANNELS)) chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sequence_start(sequence_start),
  .digital_buffer_enable_bits(digital_buffer_enable_bits), .sequence_abort(sequence_abort));

// >>> dv/arc_pin_model.sv
`timescale 1ns/100ps
module arc_pin_model (
  input wire logic ref_clk,
  output logic [15:0] analog_input_channel = 16'h0000,
  output logic [3:0] external_trigger_input = 4'h0,
  output logic conv_valid = 1'b0,
  output logic [3:0] conv_index = 4'h0,
  output logic [11:0] conv_raw = 12'h000
);
  task automatic drive(input logic [15:0] v);
    analog_input_channel <= v;
  endtask : drive
  // held two cycles so the pin synchroniser cannot miss it
  task automatic fire(input int i);
    external_trigger_input[i] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    external_trigger_input[i] <= 1'b0;
  endtask : fire
  task automatic convert(input logic [3:0] n, input logic [11:0] v);
    conv_index <= n;
    conv_raw <= v;
    conv_valid <= 1'b1;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    conv_raw <= ~v;
  endtask : convert
endmodule : arc_pin_model

// >>> dv/test_adc_result_compare_config.sv
`timescale 1ns/100ps
module test_adc_result_compare_config
  import arc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, digital_buffer_enable_bits, analog_input_channel, starts = 16'h0000;
  logic [3:0] external_trigger_input, conv_index;
  logic [11:0] conv_raw, v;
  logic conv_valid, sequence_start, sequence_abort, irq;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  arc_converter_ctrl #(.CHANNELS(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_input_channel(analog_input_channel),
    .external_trigger_input(external_trigger_input), .sequence_abort(sequence_abort),
    .digital_buffer_enable_bits(digital_buffer_enable_bits), .sequence_start(sequence_start),
    .conv_valid(conv_valid), .conv_index(conv_index), .conv_raw(conv_raw), .irq(irq));
  arc_pin_model pins (.ref_clk(ref_clk), .analog_input_channel(analog_input_channel),
    .external_trigger_input(external_trigger_input), .conv_valid(conv_valid),
    .conv_index(conv_index), .conv_raw(conv_raw));
  initial forever #12.5 ref_clk = ~ref_clk;
  // ==========================================
  // watchdog and start counter
  always @(posedge ref_clk) begin
    cycles++;
    if (sequence_start === 1'b1) starts++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
    @(posedge ref_clk);
  endtask : rd
  // irq is combinational, so it settles just after the write edge
  task automatic irq_is(input logic e);
    #1 check({15'h0000, irq}, {15'h0000, e});
    @(posedge ref_clk);
  endtask : irq_is
  function automatic logic [11:0] place(input logic [1:0] r, input logic j, input logic [11:0] x);
    if (r == ARC_RES_8) return j ? {4'h0, x[7:0]} : {x[7:0], 4'h0};
    else if (r == ARC_RES_10) return j ? {2'h0, x[9:0]} : {x[9:0], 2'h0};
    else return x;
  endfunction : place
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ==========================================
  // tests
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(ARC_OFS_CMP_DIR, 16'h0000);
    rd(ARC_OFS_DIG_EN, 16'h0000);
    wr(ARC_OFS_DIG_EN, 16'hA5C3);
    rd(ARC_OFS_DIG_EN, 16'hA5C3);
    pins.drive(16'h0FF0);
    repeat (4) @(posedge ref_clk);
    rd(ARC_OFS_PORT_DATA, 16'h05C0);
    clk_en <= 1'b0;
    wr(ARC_OFS_DIG_EN, 16'h0000);
    clk_en <= 1'b1;
    rd(ARC_OFS_DIG_EN, 16'hA5C3);
    $display("enable test done");
    for (int i = 0; i < 6; i++) begin
      v = 12'hDB7 >> (4 - 2 * (i / 2));
      wr(ARC_OFS_CTRL, 16'(i / 2) | 16'((i % 2) << 2));
      pins.convert(4'h0, v);
      @(posedge ref_clk);
      rd(ARC_OFS_RESULT, {4'h0, place(2'(i / 2), 1'(i % 2), v)});
    end
    check(digital_buffer_enable_bits, 16'hA5C3);
    $display("format test done");
    wr(ARC_OFS_CTRL, 16'h0002);
    wr(ARC_OFS_MASK, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      wr(ARC_OFS_CMP_FLAG, 16'hFFFF);
      wr(ARC_OFS_STATUS, 16'h0007);
      wr(5'h02, 16'h0800);
      wr(ARC_OFS_CMP_DIR, 16'(k / 2) << 1);
      rd(ARC_OFS_CMP_DIR, 16'(k / 2) << 1);
      pins.convert(4'h1, 12'h800 + 12'(k % 2));
      @(posedge ref_clk);
      rd(ARC_OFS_CMP_FLAG, (k == 0 || k == 3) ? 16'h0002 : 16'h0000);
      irq_is(k == 0 || k == 3);
    end
    wr(ARC_OFS_MASK, 16'h0000);
    irq_is(1'b0);
    wr(ARC_OFS_MASK, 16'h0002);
    irq_is(1'b1);
    wr(ARC_OFS_STATUS, 16'h0002);
    irq_is(1'b0);
    $display("compare test done");
    wr(ARC_OFS_CTRL, 16'h0012);
    for (int i = 0; i < 4; i++) begin
      wr(ARC_OFS_TRIG_SEL, 16'h0001 << i);
      pins.fire(i);
      repeat (6) @(posedge ref_clk);
      check(starts, 16'(i + 1));
    end
    $display("trigger test done");
    rd(5'h1E, 16'h0000);
    rd(5'h01, 16'h0000);
    $display("unmapped test done");
    stop_test();
  end
endmodule : test_adc_result_compare_config
